// >>> rtl/mbx_exchange.sv
/*
  System-bus exchange: mode register, bus ownership, page decode and the
  slave path for other masters.
  Assumes cpuReq is on ref_clk; all bus pins are asynchronous.
*/
// Notes on behaviour
// - an 8-bit mode register written by software sets the card's modes.
// - mode bits 4 and 5 choose the bus release policy.
// - policies: release after every transfer, only at opcode fetches, or never.
// - request and grant let up to 16 masters share the bus without conflict.
// - both parallel request lines and the serial priority chain are supported.
// - on-board memory and I/O accesses never request the system bus.
// - RAM, ROM and I/O are each opened or closed to other masters; closed ones stay silent.
// - an accepted access from another master is acknowledged within 625 to 750 ns; the card acks 8 to 9 cycles (800 to 900 ns) after the command pin.
// - on-board RAM and ROM are decoded by a writable lookup of 1 KB pages.
// - two complete maps exist and software selects which one decodes.
// - opcode-fetch policy releases only at a fetch; every-transfer policy after each one.
// - the first map is used after reset; bit 6 of the map output picks the second.
// - an external disable input blocks every access from the system bus.
`timescale 1ns/1ps
`default_nettype none
module mbx_exchange (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire mbx_pkg::mbx_cpu_req_t cpuReq,
  output logic                      cpuReady,
  output logic                      cpuLocal,
  output logic               [7:0]  cpuRdata,
  output logic                      busReq_n,
  input  wire logic                 busPrioIn_n,
  output logic                      busPrioOut_n,
  input  wire logic                 busBusyIn_n,
  output logic                      busBusyOut,
  output logic                      busBusyOe,
  input  wire logic                 commonReqIn_n,
  output logic                      commonReqOut,
  output logic                      commonReqOe,
  input  wire logic          [15:0] sysAddrIn,
  output logic               [15:0] sysAddrOut,
  output logic                      sysAddrOe,
  input  wire logic          [7:0]  sysDataIn,
  output logic               [7:0]  sysDataOut,
  output logic                      sysDataOe,
  input  wire mbx_pkg::mbx_cmd_t     cmdIn_n,
  output mbx_pkg::mbx_cmd_t          cmdOut_n,
  output logic                      cmdOe,
  input  wire logic                 xackIn_n,
  output logic                      xackOut_n,
  output logic                      xackOe,
  input  wire logic                 boardDisable,
  input  wire logic          [2:0]  protAllow,
  output mbx_pkg::mbx_slv_req_t      slvReq,
  input  wire logic          [7:0]  slvRdata
);
  typedef enum logic [1:0] {M_IDLE, M_DECODE, M_ARB, M_CMD} mbx_mst_state_t;
  typedef enum logic [2:0] {S_IDLE, S_LOOK, S_WAIT, S_ACK, S_IGNORE} mbx_slv_state_t;

  // ==========================================================================
  // pin synchronisers, all bus inputs in active-high form
  mbx_pkg::mbx_pins_t pinsRaw, pinsMeta_q, pins_q;

  assign pinsRaw = '{prio: ~busPrioIn_n, busy: ~busBusyIn_n, creq: ~commonReqIn_n,
                     cmd: ~cmdIn_n, xack: ~xackIn_n, blocked: boardDisable,
                     allow: protAllow, addr: sysAddrIn, data: sysDataIn};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pinsMeta_q <= '0;
      pins_q     <= '0;
    end else begin
      pinsMeta_q <= pinsRaw;
      pins_q     <= pinsMeta_q;
    end
  end

  // ==========================================================================
  // state declarations
  mbx_mst_state_t        mstState_q, mstState_d;
  mbx_pkg::mbx_cpu_req_t req_q, req_d;
  logic                  ownBus_q, ownBus_d;
  logic                  cpuReady_q, cpuReady_d;
  logic                  cpuLocal_q, cpuLocal_d;
  logic [7:0]            cpuRdata_q, cpuRdata_d;
  logic [7:0]            mode_q, mode_d;
  logic                  mapSel_q, mapSel_d;
  logic [6:0]            tblIdx_q, tblIdx_d;
  logic                  tblWr;
  mbx_slv_state_t        slvState_q, slvState_d;
  mbx_pkg::mbx_slv_req_t slvReq_q, slvReq_d;
  logic [2:0]            slvCnt_q, slvCnt_d;
  logic [7:0]            slvData_q, slvData_d;
  logic [1:0]            kindA, kindB;
  mbx_pkg::mbx_policy_t  policy;
  logic                  otherWants, isLocal, wantBus, cmdAnyIn, slvAllowed;

  // ==========================================================================
  // page lookup; one map select serves both decodes
  mbx_map_table u_map (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wrEn    (tblWr),
    .wrIdx   (tblIdx_q),
    .wrKind  (req_q.wdata[1:0]),
    .rdIdxA  ({mapSel_q, cpuReq.addr[15:mbx_pkg::PAGE_LSB]}),
    .rdIdxB  ({mapSel_q, pins_q.addr[15:mbx_pkg::PAGE_LSB]}),
    .rdKindA (kindA),
    .rdKindB (kindB)
  );

  // ==========================================================================
  // master side: local decode, bus acquisition and release
  assign policy     = mbx_pkg::policyOf(mode_q);
  assign otherWants = pins_q.creq || !pins_q.prio;
  assign isLocal    = req_q.io ? mbx_pkg::ioLocal(req_q.addr[7:0])
                               : (kindA != mbx_pkg::KIND_NONE);

  always_comb begin
    mstState_d = mstState_q;
    req_d      = req_q;
    ownBus_d   = ownBus_q;
    cpuReady_d = 1'b0;
    cpuLocal_d = cpuLocal_q;
    cpuRdata_d = cpuRdata_q;
    mode_d     = mode_q;
    mapSel_d   = mapSel_q;
    tblIdx_d   = tblIdx_q;
    tblWr      = 1'b0;
    case (mstState_q)
      M_IDLE: begin
        // policy is sampled here, at decode and at transfer end, never mid-transfer
        if (ownBus_q && policy == mbx_pkg::POL_EVERY && otherWants) begin
          ownBus_d = 1'b0;
        end
        if (cpuReq.valid) begin
          req_d      = cpuReq;
          mstState_d = M_DECODE;
        end
      end
      M_DECODE: begin
        if (req_q.opcodeFetchCycle && ownBus_q && policy == mbx_pkg::POL_INSTR
            && otherWants) begin
          ownBus_d = 1'b0;
        end
        if (isLocal) begin
          // served on board, system bus left free
          cpuReady_d = 1'b1;
          cpuLocal_d = 1'b1;
          cpuRdata_d = 8'h00;
          mstState_d = M_IDLE;
          if (req_q.io && req_q.write) begin
            case (req_q.addr[7:0])
              mbx_pkg::MODE_PORT:     mode_d   = req_q.wdata;
              mbx_pkg::MAP_PORT:      mapSel_d = req_q.wdata[mbx_pkg::MAP_SEL_BIT];
              mbx_pkg::TBL_IDX_PORT:  tblIdx_d = req_q.wdata[6:0];
              mbx_pkg::TBL_DATA_PORT: tblWr    = 1'b1;
              default: ;
            endcase
          end else if (req_q.io) begin
            case (req_q.addr[7:0])
              mbx_pkg::MODE_PORT:    cpuRdata_d = mode_q;
              mbx_pkg::TBL_IDX_PORT: cpuRdata_d = {1'b0, tblIdx_q};
              mbx_pkg::STATUS_PORT: begin
                cpuRdata_d[mbx_pkg::ST_OWN]   = ownBus_q;
                cpuRdata_d[mbx_pkg::ST_SLAVE] = slvState_q != S_IDLE;
                cpuRdata_d[mbx_pkg::ST_MAP]   = mapSel_q;
              end
              default: ;
            endcase
          end
        end else begin
          mstState_d = M_ARB;
        end
      end
      M_ARB: begin
        // take the bus only with priority in hand and nobody else holding it
        if (ownBus_q) begin
          mstState_d = M_CMD;
        end else if (pins_q.prio && !pins_q.busy) begin
          ownBus_d   = 1'b1;
          mstState_d = M_CMD;
        end
      end
      M_CMD: begin
        if (pins_q.xack) begin
          cpuReady_d = 1'b1;
          cpuLocal_d = 1'b0;
          cpuRdata_d = pins_q.data;
          mstState_d = M_IDLE;
          if (policy == mbx_pkg::POL_EVERY && otherWants) begin
            ownBus_d = 1'b0;
          end
        end
      end
      default: mstState_d = M_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mstState_q <= M_IDLE;
      req_q      <= '0;
      ownBus_q   <= 1'b0;
      cpuReady_q <= 1'b0;
      cpuLocal_q <= 1'b0;
      cpuRdata_q <= 8'h00;
      mode_q     <= mbx_pkg::MODE_RESET;
      mapSel_q   <= mbx_pkg::MAP_RESET;
      tblIdx_q   <= mbx_pkg::TBL_IDX_RESET;
    end else begin
      mstState_q <= mstState_d;
      req_q      <= req_d;
      ownBus_q   <= ownBus_d;
      cpuReady_q <= cpuReady_d;
      cpuLocal_q <= cpuLocal_d;
      cpuRdata_q <= cpuRdata_d;
      mode_q     <= mode_d;
      mapSel_q   <= mapSel_d;
      tblIdx_q   <= tblIdx_d;
    end
  end

  // ==========================================================================
  // slave side: accesses from other masters
  assign cmdAnyIn   = |pins_q.cmd;
  assign slvAllowed = slvReq_q.io
    ? (mbx_pkg::ioLocal(slvReq_q.addr[7:0]) && pins_q.allow[mbx_pkg::ALLOW_IO])
    : ((kindB == mbx_pkg::KIND_RAM && pins_q.allow[mbx_pkg::ALLOW_RAM])
       || (kindB == mbx_pkg::KIND_ROM && pins_q.allow[mbx_pkg::ALLOW_ROM]
           && !slvReq_q.write));

  always_comb begin
    slvState_d = slvState_q;
    slvReq_d   = slvReq_q;
    slvCnt_d   = slvCnt_q;
    slvData_d  = slvData_q;
    case (slvState_q)
      S_IDLE: begin
        // our own master cycle is not answered by our own slave
        if (cmdAnyIn && !ownBus_q) begin
          if (pins_q.blocked) begin
            slvState_d = S_IGNORE;
          end else begin
            slvReq_d.valid = 1'b0;
            slvReq_d.write = pins_q.cmd.mwtc || pins_q.cmd.iowc;
            slvReq_d.io    = pins_q.cmd.iorc || pins_q.cmd.iowc;
            slvReq_d.addr  = pins_q.addr;
            slvReq_d.wdata = pins_q.data;
            slvCnt_d       = 3'h1;
            slvState_d     = S_LOOK;
          end
        end
      end
      S_LOOK: begin
        if (slvAllowed && !pins_q.blocked) begin
          slvReq_d.valid = 1'b1;
          slvCnt_d       = slvCnt_q + 3'h1;
          slvState_d     = S_WAIT;
        end else begin
          slvState_d = S_IGNORE;
        end
      end
      S_WAIT: begin
        slvCnt_d = slvCnt_q + 3'h1;
        if (slvCnt_q == 3'(mbx_pkg::ACK_CYC - 1)) begin
          slvReq_d.valid = 1'b0;
          slvData_d      = slvRdata;
          slvState_d     = S_ACK;
        end
      end
      S_ACK: begin
        if (!cmdAnyIn) begin
          slvState_d = S_IDLE;
        end
      end
      S_IGNORE: begin
        if (!cmdAnyIn) begin
          slvState_d = S_IDLE;
        end
      end
      default: slvState_d = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      slvState_q <= S_IDLE;
      slvReq_q   <= '0;
      slvCnt_q   <= 3'h0;
      slvData_q  <= 8'h00;
    end else begin
      slvState_q <= slvState_d;
      slvReq_q   <= slvReq_d;
      slvCnt_q   <= slvCnt_d;
      slvData_q  <= slvData_d;
    end
  end

  // ==========================================================================
  // outputs
  assign wantBus      = (mstState_q == M_ARB) || (mstState_q == M_CMD);
  assign busReq_n     = ~wantBus;
  // chain passes priority only while this card neither wants nor holds the bus
  assign busPrioOut_n = ~(pins_q.prio && !wantBus && !ownBus_q);
  assign busBusyOut   = 1'b0;
  assign busBusyOe    = ownBus_q;
  assign commonReqOut = 1'b0;
  assign commonReqOe  = (mstState_q == M_ARB) && !ownBus_q;
  assign sysAddrOut   = req_q.addr;
  assign sysAddrOe    = mstState_q == M_CMD;
  assign sysDataOut   = (slvState_q == S_ACK) ? slvData_q : req_q.wdata;
  assign sysDataOe    = ((mstState_q == M_CMD) && req_q.write)
                        || ((slvState_q == S_ACK) && !slvReq_q.write);
  assign cmdOut_n     = ~{!req_q.io && !req_q.write, !req_q.io && req_q.write,
                          req_q.io && !req_q.write, req_q.io && req_q.write};
  assign cmdOe        = mstState_q == M_CMD;
  assign xackOut_n    = 1'b0;
  assign xackOe       = slvState_q == S_ACK;
  assign slvReq       = slvReq_q;
  assign cpuReady     = cpuReady_q;
  assign cpuLocal     = cpuLocal_q;
  assign cpuRdata     = cpuRdata_q;
endmodule // mbx_exchange
`default_nettype wire

// >>> rtl/mbx_pkg.sv
/*
  Constants, types and decode functions of the system-bus exchange block.
  Assumes a 10 MHz ref_clk; the local processor writes the mode register by I/O output.
*/
`default_nettype none
package mbx_pkg;
  // ==========================================================================
  // mode register layout
  localparam int         MODE_POLICY_LO = 4;
  localparam int         MODE_POLICY_HI = 5;
  localparam int         MAP_SEL_BIT    = 6;
  localparam logic [7:0] MODE_RESET     = 8'h00;
  localparam logic       MAP_RESET      = 1'b0;

  // ==========================================================================
  // local I/O ports
  localparam logic [7:0] MODE_PORT        = 8'h70;
  localparam logic [7:0] MAP_PORT         = 8'h71;
  localparam logic [7:0] TBL_IDX_PORT     = 8'h72;
  localparam logic [7:0] TBL_DATA_PORT    = 8'h73;
  localparam logic [7:0] STATUS_PORT      = 8'h74;
  localparam logic [7:0] IO_OFFBOARD_BASE = 8'hc0;
  localparam logic [6:0] TBL_IDX_RESET    = 7'h00;

  // status port bit positions
  localparam int ST_OWN   = 0;
  localparam int ST_SLAVE = 1;
  localparam int ST_MAP   = 2;

  // ==========================================================================
  // address map: 1 KB pages in a 64 KB space
  localparam int         PAGE_LSB      = 10;
  localparam logic [5:0] MAP0_ROM_END  = 6'h10;
  localparam logic [5:0] MAP0_RAM_END  = 6'h30;
  localparam logic [5:0] MAP1_RAM_END  = 6'h20;
  localparam logic [5:0] MAP1_ROM_BASE = 6'h30;

  // protection input bit positions
  localparam int ALLOW_RAM = 0;
  localparam int ALLOW_ROM = 1;
  localparam int ALLOW_IO  = 2;

  // ==========================================================================
  // timing of an accepted access from another master
  localparam int CLK_PERIOD_NS = 100;
  localparam int DMA_MIN_NS    = 625;
  localparam int DMA_MAX_NS    = 750;
  localparam int ACK_MIN_CYC   = (DMA_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACK_MAX_CYC   = DMA_MAX_NS / CLK_PERIOD_NS;
  localparam int ACK_CYC       = ACK_MIN_CYC;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {POL_EVERY, POL_INSTR, POL_NEVER} mbx_policy_t;
  typedef enum logic [1:0] {KIND_NONE, KIND_RAM, KIND_ROM} mbx_kind_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        io;
    logic        opcodeFetchCycle;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mbx_cpu_req_t;

  typedef struct packed {
    logic mrdc;
    logic mwtc;
    logic iorc;
    logic iowc;
  } mbx_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        io;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mbx_slv_req_t;

  typedef struct packed {
    logic        prio;
    logic        busy;
    logic        creq;
    mbx_cmd_t    cmd;
    logic        xack;
    logic        blocked;
    logic [2:0]  allow;
    logic [15:0] addr;
    logic [7:0]  data;
  } mbx_pins_t;

  // ==========================================================================
  // functions
  // policy bits: 00 every transfer, 01 opcode fetch only, 1x keep the bus
  function automatic mbx_policy_t policyOf(input logic [7:0] mode);
    if (mode[MODE_POLICY_HI]) begin
      return POL_NEVER;
    end
    return mode[MODE_POLICY_LO] ? POL_INSTR : POL_EVERY;
  endfunction

  function automatic logic ioLocal(input logic [7:0] port);
    return port < IO_OFFBOARD_BASE;
  endfunction

  function automatic logic [1:0] defaultKind(input logic [6:0] idx);
    logic [5:0] page;
    page = idx[5:0];
    if (!idx[6]) begin
      if (page < MAP0_ROM_END) return KIND_ROM;
      if (page < MAP0_RAM_END) return KIND_RAM;
      return KIND_NONE;
    end
    if (page < MAP1_RAM_END)   return KIND_RAM;
    if (page >= MAP1_ROM_BASE) return KIND_ROM;
    return KIND_NONE;
  endfunction
endpackage
`default_nettype wire

// >>> rtl/mbx_map_table.sv
/*
  Page lookup: two maps of 64 1 KB pages, each entry a region kind.
  Assumes local processor writes; reads are registered, one cycle late.
*/
`timescale 1ns/1ps
`default_nettype none
module mbx_map_table (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       wrEn,
  input  wire logic [6:0] wrIdx,
  input  wire logic [1:0] wrKind,
  input  wire logic [6:0] rdIdxA,
  input  wire logic [6:0] rdIdxB,
  output logic      [1:0] rdKindA,
  output logic      [1:0] rdKindB
);
  logic [1:0] mem [0:127];

  // ==========================================================================
  // storage, reloaded with the start-up maps on reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 128; i++) begin
        mem[i] <= mbx_pkg::defaultKind(7'(i));
      end
      rdKindA <= 2'h0;
      rdKindB <= 2'h0;
    end else begin
      if (wrEn) begin
        mem[wrIdx] <= wrKind;
      end
      rdKindA <= mem[rdIdxA];
      rdKindB <= mem[rdIdxB];
    end
  end
endmodule // mbx_map_table
`default_nettype wire

// >>> test/mbx_exchange_assertions.sv
/*
  Port checker of the exchange block.
  Assumes binding into mbx_exchange, all ports on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mbx_exchange_assertions (
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire mbx_pkg::mbx_cpu_req_t cpuReq,
  input wire logic                  cpuReady,
  input wire logic                  cpuLocal,
  input wire logic                  busReq_n,
  input wire logic                  busPrioOut_n,
  input wire logic                  busBusyOe,
  input wire logic                  cmdOe,
  input wire logic                  xackOe,
  input wire mbx_pkg::mbx_slv_req_t slvReq,
  input wire logic                  boardDisable,
  input wire logic [2:0]            protAllow
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // slave path
  sequence s_wait; slvReq.valid [*5]; endsequence
  sequence s_ack; ##1 xackOe; endsequence
  property p_slave_wait; $rose(slvReq.valid) |-> s_wait ##0 s_ack; endproperty
  a_slave_wait: assert property (p_slave_wait) else $error("slave ack timing");
  property p_ack_cause; $rose(xackOe) |-> $past(slvReq.valid, 5) && $past(slvReq.valid); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without wait");
  property p_disabled; boardDisable [*8] |-> !$rose(xackOe); endproperty
  a_disabled: assert property (p_disabled) else $error("disabled card answered");
  property p_closed; (protAllow == 3'h0) [*8] |-> !$rose(slvReq.valid); endproperty
  a_closed: assert property (p_closed) else $error("closed resource reached");
  // ==========================================================================
  // master path
  property p_local_fast;
    cpuReq.valid && cpuReq.io && cpuReq.addr[7:0] < 8'hc0 |-> ##2 cpuReady && cpuLocal;
  endproperty
  a_local_fast: assert property (p_local_fast) else $error("local access late");
  property p_cmd_owner; cmdOe |-> busBusyOe; endproperty
  a_cmd_owner: assert property (p_cmd_owner) else $error("command not owner");
  property p_chain; !busPrioOut_n |-> busReq_n && !busBusyOe; endproperty
  a_chain: assert property (p_chain) else $error("priority passed on");
  property p_cmd_hold; cmdOe && !cpuReady |=> cmdOe || cpuReady; endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("bus transfer aborted");
  property p_cmd_bound; $rose(cmdOe) |-> ##[1:40] cpuReady; endproperty
  a_cmd_bound: assert property (p_cmd_bound) else $error("transfer hung");
endmodule // mbx_exchange_assertions

bind mbx_exchange mbx_exchange_assertions i_chk (.ref_clk, .rst, .cpuReq, .cpuReady,
  .cpuLocal, .busReq_n, .busPrioOut_n, .busBusyOe, .cmdOe, .xackOe, .slvReq, .boardDisable,
  .protAllow);
`default_nettype wire

// >>> test/mbx_bus_partner.sv
/*
  Other masters and the arbiter of the system bus.
  Assumes the bench resolves shared lines and sets grantEn and ackDelay.
*/
`timescale 1ns/1ps
`default_nettype none
module mbx_bus_partner (
  input  wire logic              ref_clk,
  input  wire logic              busReq_n,
  input  wire mbx_pkg::mbx_cmd_t cardCmd_n,
  input  wire logic              cardCmdOe,
  input  wire logic [15:0]       busAddr,
  input  wire logic [7:0]        busData,
  input  wire logic              xackBus_n,
  output logic                   busPrioIn_n,
  output var logic               ackDrv,
  output var logic [7:0]         dataDrv,
  output var mbx_pkg::mbx_cmd_t  cmdDrv_n,
  output var logic [15:0]        addrDrv,
  output var logic               busyDrv
);
  logic grantEn = 1'b1;
  int   ackDelay = 1;
  int   waitCnt = 0;
  initial begin
    ackDrv = 1'b0;
    dataDrv = 8'h00;
    cmdDrv_n = 4'hf;
    addrDrv = 16'h0000;
    busyDrv = 1'b0;
  end
  // grantEn low stands for a higher-priority master
  assign busPrioIn_n = !(grantEn && !busReq_n);
  // ==========================================================================
  // slave answer; an idle data line toggles so stale data cannot pass
  always @(posedge ref_clk) begin
    if (cardCmdOe && cardCmd_n !== 4'hf) begin
      waitCnt <= waitCnt + 1;
      ackDrv  <= waitCnt >= ackDelay;
      dataDrv <= busAddr[7:0] ^ 8'h5a;
    end else begin
      waitCnt <= 0;
      ackDrv  <= 1'b0;
      if (!busyDrv) dataDrv <= ~dataDrv;
    end
  end
  // ==========================================================================
  // one byte access to the card; n counts cycles until ack, seen off the edge
  task automatic access(input logic w, io, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output logic ok, output int n);
    n = 0;
    @(negedge ref_clk);
    busyDrv = 1'b1;
    addrDrv = a;
    dataDrv = d;
    cmdDrv_n = ~{!w && !io, w && !io, !w && io, w && io};
    while (xackBus_n !== 1'b0 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    rd = busData;
    ok = !xackBus_n;
    @(negedge ref_clk);
    cmdDrv_n = 4'hf;
    busyDrv = 1'b0;
    addrDrv = ~a;
  endtask
endmodule // mbx_bus_partner
`default_nettype wire

// >>> test/multimaster_bus_exchange_interface_bench.sv
/*
  Self-checking bench of the exchange block.
  Assumes the package is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module multimaster_bus_exchange_interface_bench;
  mbx_pkg::mbx_cpu_req_t cpuReq = '0;
  mbx_pkg::mbx_cmd_t     cmdOut_n, cmdDrv_n;
  mbx_pkg::mbx_slv_req_t slvReq;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        boardDisable = 1'b0;
  logic        otherReq = 1'b0;
  logic [2:0]  protAllow = 3'h7;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  logic        cpuReady, cpuLocal, busReq_n, busPrioIn_n, busPrioOut_n;
  logic        busBusyOut, busBusyOe, commonReqOut, commonReqOe, sysAddrOe;
  logic        sysDataOe, cmdOe, xackOut_n, xackOe, ackDrv, busyDrv;
  logic [7:0]  cpuRdata, sysDataOut, dataDrv;
  logic [15:0] sysAddrOut, addrDrv;
  // ==========================================================================
  // open-drain lines are wired-and, the rest muxed by driver
  wire mbx_pkg::mbx_cmd_t cmdBus_n = cmdOe ? cmdOut_n : cmdDrv_n;
  wire logic        busBusyIn_n = !(busBusyOe && !busBusyOut) && !busyDrv;
  wire logic        commonReq_n = !(commonReqOe && !commonReqOut) && !otherReq;
  wire logic        xackBus_n = !(xackOe && !xackOut_n) && !ackDrv;
  wire logic [15:0] addrBus = sysAddrOe ? sysAddrOut : addrDrv;
  wire logic [7:0]  dataBus = sysDataOe ? sysDataOut : dataDrv;
  wire logic [7:0]  slvRdata = slvReq.addr[7:0] ^ 8'h3c;
  // {disable, allow[2:0], write, io, 0, ack expected, addr[15:0]}
  localparam logic [23:0] CASES [9] = '{24'h714055, 24'h794066, 24'h780011, 24'h710022,
    24'h004033, 24'h340020, 24'h750021, 24'hf04044, 24'h70c000};

  mbx_exchange i_dut (.ref_clk, .rst, .cpuReq, .cpuReady, .cpuLocal, .cpuRdata, .busReq_n,
    .busPrioIn_n, .busPrioOut_n, .busBusyIn_n, .busBusyOut, .busBusyOe,
    .commonReqIn_n(commonReq_n), .commonReqOut, .commonReqOe, .sysAddrIn(addrBus),
    .sysAddrOut, .sysAddrOe, .sysDataIn(dataBus), .sysDataOut, .sysDataOe,
    .cmdIn_n(cmdBus_n), .cmdOut_n, .cmdOe, .xackIn_n(xackBus_n), .xackOut_n, .xackOe,
    .boardDisable, .protAllow, .slvReq, .slvRdata);
  mbx_bus_partner i_far (.ref_clk, .busReq_n, .cardCmd_n(cmdOut_n), .cardCmdOe(cmdOe),
    .busAddr(addrBus), .busData(dataBus), .xackBus_n, .busPrioIn_n, .ackDrv, .dataDrv,
    .cmdDrv_n, .addrDrv, .busyDrv);

  initial forever #50 ref_clk = ~ref_clk;
  // ==========================================================================
  // bus tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // valid is a one-cycle pulse
  task automatic cpu(input logic w, io, f, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    cpuReq = {1'b1, w, io, f, a, d};
    @(negedge ref_clk);
    cpuReq.valid = 1'b0;
    while (cpuReady !== 1'b1 && n < 80) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("cpu ready", 1'b1, cpuReady)
  endtask
  task automatic io(input logic w, input logic [7:0] port, input logic [7:0] d);
    cpu(w, 1'b1, 1'b0, {8'h00, port}, d);
  endtask
  task automatic slv(input logic [23:0] c);
    logic [7:0] rd;
    logic       ok;
    int         n;
    @(negedge ref_clk);
    boardDisable = c[23];
    protAllow = c[22:20];
    repeat (4) @(negedge ref_clk);
    i_far.access(c[19], c[18], c[15:0], c[7:0] ^ 8'h99, rd, ok, n);
    `CHK("slave ack", c[16], ok)
    if (ok && !c[19]) `CHK("slave data", c[7:0] ^ 8'h3c, rd)
    if (ok) `CHK("slave time", 1'b1, n >= 7 && n <= 12)
    boardDisable = 1'b0;
    protAllow = 3'h7;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    io(1'b0, mbx_pkg::MODE_PORT, 8'h00);
    `CHK("mode reset", mbx_pkg::MODE_RESET, cpuRdata)
    io(1'b0, mbx_pkg::STATUS_PORT, 8'h00);
    `CHK("map reset", mbx_pkg::MAP_RESET, cpuRdata[mbx_pkg::ST_MAP])
    io(1'b1, mbx_pkg::MODE_PORT, 8'h35);
    io(1'b0, mbx_pkg::MODE_PORT, 8'h00);
    `CHK("mode rw", 8'h35, cpuRdata)
    io(1'b1, mbx_pkg::MODE_PORT, 8'h00);
    cpu(1'b0, 1'b0, 1'b0, 16'h4000, 8'h00);
    `CHK("local ram", 1'b1, cpuLocal)
    $display("register test done");
  endtask
  task automatic t_map();
    io(1'b1, mbx_pkg::MAP_PORT, 8'h40);
    io(1'b0, mbx_pkg::STATUS_PORT, 8'h00);
    `CHK("map select", 1'b1, cpuRdata[mbx_pkg::ST_MAP])
    slv(24'h71c000);
    slv(24'h790020);
    io(1'b1, mbx_pkg::MAP_PORT, 8'h00);
    io(1'b1, mbx_pkg::TBL_IDX_PORT, 8'h30);
    io(1'b1, mbx_pkg::TBL_DATA_PORT, 8'h01);
    io(1'b0, mbx_pkg::TBL_IDX_PORT, 8'h00);
    `CHK("table index", 8'h30, cpuRdata)
    slv(24'h79c010);
    cpu(1'b0, 1'b0, 1'b0, 16'hc005, 8'h00);
    `CHK("new ram local", 1'b1, cpuLocal)
    $display("map test done");
  endtask
  task automatic t_policy();
    for (int p = 0; p < 3; p++) begin
      i_far.ackDelay = 1 + 4 * p;
      io(1'b1, mbx_pkg::MODE_PORT, 8'(p << 4));
      cpu(1'b0, 1'b0, 1'b0, 16'hf123, 8'h00);
      `CHK("bus read", 8'h23 ^ 8'h5a, cpuRdata)
      `CHK("bus used", 1'b0, cpuLocal)
      otherReq = 1'b1;
      i_far.grantEn = 1'b0;
      repeat (8) @(negedge ref_clk);
      io(1'b0, mbx_pkg::STATUS_PORT, 8'h00);
      `CHK("owner kept", p != 0, cpuRdata[mbx_pkg::ST_OWN])
      if (p == 1) begin
        cpu(1'b0, 1'b0, 1'b1, 16'h4000, 8'h00);
        io(1'b0, mbx_pkg::STATUS_PORT, 8'h00);
        `CHK("fetch release", 1'b0, cpuRdata[mbx_pkg::ST_OWN])
      end
      otherReq = 1'b0;
      i_far.grantEn = 1'b1;
    end
    $display("policy test done");
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    t_regs();
    foreach (CASES[i]) slv(CASES[i]);
    $display("slave test done");
    t_map();
    t_policy();
    report_and_stop();
  end
endmodule // multimaster_bus_exchange_interface_bench
`default_nettype wire
